// file: hdl/reset_cause_status_capture.sv
// top of the reset cause capture: status register, enables, debug
// force reset, watchdog restart strobe and an interrupt pair
// assumes rst_i is the chip reset; cause inputs are held during it
//
// Our own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ns
module reset_cause_status_capture (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone classic slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [4:0]  adr_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   // debug port: high when access comes from serial background debug
   input  wire logic        debug_access_i,
   // reset cause levels, sampled while rst_i is high
   input  wire logic        power_on_i,
   input  wire logic        supply_low_i,
   input  wire logic        reset_pin_n_i,
   input  wire logic        watchdog_timeout_i,
   input  wire logic        bad_opcode_i,
   input  wire logic        stop_exec_i,
   input  wire logic        enter_background_instruction_exec_i,
   input  wire logic        bad_address_i,
   input  wire logic        wakeup_i,
   input  wire logic        stop12_mode_i,
   // outputs
   output logic             watchdog_restart_o,
   output logic             reset_req_o,
   output logic [7:0]       reset_cause_status_o,
   output logic             irq_o
);
   // ----------------------------------------------------------------
   // bus front end
   // ----------------------------------------------------------------
   logic       ack_nxt;
   logic       wr_p;
   logic       rd_p;
   rcs_wb_slave u_wb (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .cyc_i  (cyc_i),
      .stb_i  (stb_i),
      .ack_o  (ack_nxt),
      .wr_p_o (),
      .rd_p_o ()
   );
   assign ack_o = ack_nxt;
   // write takes effect in the ack cycle, when the master samples it
   assign wr_p = ack_nxt & cyc_i & stb_i & we_i;
   assign rd_p = ack_nxt & cyc_i & stb_i & ~we_i;

   logic [7:0] status_r;
   logic [4:0] ctrl_r;
   logic [rcs_pkg::IRQ_W-1:0] irq_stat_r;
   logic [rcs_pkg::IRQ_W-1:0] irq_mask_r;
   logic [7:0] pattern;
   logic       lv_reset;
   logic       bad_op_any;
   logic       forced_r;

   // reset_req_o is cleared on the first reset edge, so the fact that
   // the reset was debug forced is kept here for the rest of reset
   always_ff @(posedge clk_i) begin
      if (!rst_i) begin
         forced_r <= 1'b0;
      end else if (reset_req_o) begin
         forced_r <= 1'b1;                                       // R02
      end
   end

   // ----------------------------------------------------------------
   // cause qualification
   // ----------------------------------------------------------------
   // low-voltage reset only with both enables set and supply tripped
   assign lv_reset = supply_low_i
                   & ctrl_r[rcs_pkg::CTRL_LV_RESET_EN]
                   & ctrl_r[rcs_pkg::CTRL_LV_STOP_EN];           // R14
   // stop or background with their modes off count as bad opcodes
   assign bad_op_any = bad_opcode_i
      | (stop_exec_i & ~ctrl_r[rcs_pkg::CTRL_STOP_EN])           // R10
      | (enter_background_instruction_exec_i & ~ctrl_r[rcs_pkg::CTRL_ENTER_BACKGROUND_INSTRUCTION_EN]);          // R11

   rcs_cause_sel u_sel (
      .power_on_i (power_on_i),
      .low_volt_i (lv_reset),
      .debug_i    (reset_req_o | forced_r),                      // R02
      .pin_i      (~reset_pin_n_i),                              // R07
      .watchdog_i (watchdog_timeout_i
                   & ctrl_r[rcs_pkg::CTRL_WATCHDOG_EN]),         // R08
      .bad_op_i   (bad_op_any),
      .bad_addr_i (bad_address_i),
      .wakeup_i   (wakeup_i & ~stop12_mode_i),                   // R13
      .pattern_o  (pattern)
   );

   // ----------------------------------------------------------------
   // status register: loaded during reset, frozen afterwards
   // ----------------------------------------------------------------
   // no software path reaches status_r, so reads/writes cannot move it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_r <= pattern;                                    // R06
      end
   end                                                           // R16
   // bit 0 is hard zero
   always_ff @(posedge clk_i) begin
      reset_cause_status_o <= {status_r[7:1], 1'b0};             // R01
   end

   // ----------------------------------------------------------------
   // control: enables survive only until next reset
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= rcs_pkg::CTRL_RESET;
      end else if (wr_p && adr_i == {1'b0, rcs_pkg::ADDR_CTRL}
                   && sel_i[0]) begin
         ctrl_r <= dat_i[4:0];
      end
   end

   // ----------------------------------------------------------------
   // watchdog restart pulse and held debug force reset request
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         watchdog_restart_o <= 1'b0;
      end else begin
         watchdog_restart_o <= wr_p
            && adr_i == {1'b0, rcs_pkg::ADDR_STATUS};            // R03
      end
   end
   // held until the reset it requests arrives; user writes ignored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reset_req_o <= 1'b0;
      end else if (wr_p && debug_access_i
                   && adr_i == {1'b0, rcs_pkg::ADDR_FORCE}
                   && dat_i[rcs_pkg::BIT_FORCE]) begin
         reset_req_o <= 1'b1;                                    // R15
      end
   end

   // ----------------------------------------------------------------
   // interrupts: sticky events, write one to clear, set wins
   // ----------------------------------------------------------------
   logic [rcs_pkg::IRQ_W-1:0] ev;
   logic [rcs_pkg::IRQ_W-1:0] clr;
   assign ev[rcs_pkg::EV_KICK]    = watchdog_restart_o;
   assign ev[rcs_pkg::EV_REQUEST] = reset_req_o;
   assign clr = (wr_p && adr_i == {1'b0, rcs_pkg::ADDR_IRQ_STAT})
                ? dat_i[rcs_pkg::IRQ_W-1:0] : '0;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_r <= '0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~clr) | ev;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask_r <= '0;
      end else if (wr_p && adr_i == rcs_pkg::ADDR_MASK_FULL) begin
         irq_mask_r <= dat_i[rcs_pkg::IRQ_W-1:0];
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat_r & irq_mask_r);
      end
   end

   // ----------------------------------------------------------------
   // read mux: registered, valid with ack
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= '0;
      end else begin
         case (adr_i)
            {1'b0, rcs_pkg::ADDR_STATUS}:
               dat_o <= {24'h0, status_r[7:1], 1'b0};            // R01
            {1'b0, rcs_pkg::ADDR_CTRL}:   dat_o <= {27'h0, ctrl_r};
            {1'b0, rcs_pkg::ADDR_IRQ_STAT}:
               dat_o <= {30'h0, irq_stat_r};
            rcs_pkg::ADDR_MASK_FULL:      dat_o <= {30'h0, irq_mask_r};
            default:                      dat_o <= '0;
         endcase
      end
   end
endmodule

// file: hdl/rcs_pkg.sv
// package of constants for the reset cause status capture block
// assumes a 100 MHz bus clock, classic wishbone with 32-bit data
// Function
// R01: seven read-only cause flags, bit 0 zero
// R02: debug forced reset leaves all flags clear
// R03: any write restarts watchdog, flags unchanged
// R04: power-on or low-voltage loads bits 7 and 1; low-voltage only in a one-cycle reset, as reset clears both enables
// R05: low-voltage flag also set by power-on
// R06: other resets: active bits 6..2 set, rest clear
// R07: pin flag reports external low-level reset
// R08: watchdog flag only if watchdog enabled
// R09: bad opcode flag on illegal opcode reset
// R10: stop with stop disabled is illegal opcode
// R11: background with mode disabled is illegal opcode
// R12: bad address flag on unimplemented address access
// R13: wakeup flag for wakeup reset in run, wait, stop4/3
// R14: low-voltage reset needs both enables and trip
// R15: force reset only from serial debug write
// R16: flags hold from reset end to next reset
package rcs_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_STATUS   = 4'h0; // reset cause status
   localparam logic [3:0] ADDR_FORCE    = 4'h4; // debug force reset reg
   localparam logic [3:0] ADDR_CTRL     = 4'h8; // enables
   localparam logic [3:0] ADDR_IRQ_STAT = 4'hc;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h0; // used with bit 4 of addr
   localparam logic [4:0] ADDR_MASK_FULL = 5'h10;
   // ----------------------------------------------------------------
   // status fields
   // ----------------------------------------------------------------
   localparam int BIT_POWER_ON  = 7;
   localparam int BIT_PIN       = 6;
   localparam int BIT_WATCHDOG  = 5;
   localparam int BIT_BAD_OP    = 4;
   localparam int BIT_BAD_ADDR  = 3;
   localparam int BIT_WAKEUP    = 2;
   localparam int BIT_LOW_VOLT  = 1;
   localparam logic [7:0] POWER_ON_PATTERN = 8'h82;
   localparam logic [7:0] STATUS_RESET     = 8'h82;
   // ----------------------------------------------------------------
   // control fields (reset values in ctrl register)
   // ----------------------------------------------------------------
   localparam int CTRL_WATCHDOG_EN  = 0;
   localparam int CTRL_STOP_EN      = 1;
   localparam int CTRL_ENTER_BACKGROUND_INSTRUCTION_EN      = 2;
   localparam int CTRL_LV_RESET_EN  = 3;
   localparam int CTRL_LV_STOP_EN   = 4;
   localparam logic [4:0] CTRL_RESET = 5'h01;
   localparam int BIT_FORCE = 0;
   // interrupt events: 0 watchdog restarted, 1 reset request issued
   localparam int IRQ_W        = 2;
   localparam int EV_KICK      = 0;
   localparam int EV_REQUEST   = 1;
   // ----------------------------------------------------------------
   // reset request sources
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SRC_NONE, SRC_POWER_ON, SRC_LOW_VOLT, SRC_OTHER, SRC_DEBUG
   } src_e;
endpackage

// file: hdl/rcs_wb_slave.sv
// wishbone classic slave front end: one-cycle registered ack
// assumes master holds request until ack, drops cyc/stb after it
`timescale 1ns/1ns
module rcs_wb_slave (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   output logic             ack_o,
   output logic             wr_p_o,
   output logic             rd_p_o
);
   // ack one cycle after request; never twice in a row
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= cyc_i & stb_i & ~ack_o;
      end
   end
   // access strobes tied low; the top decodes its own from ack
   assign wr_p_o = 1'b0;
   assign rd_p_o = 1'b0;
endmodule

// file: hdl/rcs_cause_sel.sv
// combinational cause pattern builder for the status register
// assumes source levels are held stable during reset
`timescale 1ns/1ns
module rcs_cause_sel (
   input  wire logic        power_on_i,
   input  wire logic        low_volt_i,
   input  wire logic        debug_i,
   input  wire logic        pin_i,
   input  wire logic        watchdog_i,
   input  wire logic        bad_op_i,
   input  wire logic        bad_addr_i,
   input  wire logic        wakeup_i,
   output logic [7:0]       pattern_o
);
   // priority: power/low voltage, then debug, then per-source bits
   always_comb begin
      pattern_o = 8'h00;
      if (power_on_i || low_volt_i) begin
         pattern_o = rcs_pkg::POWER_ON_PATTERN;                  // R04 R05
      end else if (debug_i) begin
         pattern_o = 8'h00;                                      // R02
      end else begin
         pattern_o[rcs_pkg::BIT_PIN]      = pin_i;               // R06 R07
         pattern_o[rcs_pkg::BIT_WATCHDOG] = watchdog_i;          // R08
         pattern_o[rcs_pkg::BIT_BAD_OP]   = bad_op_i;            // R09
         pattern_o[rcs_pkg::BIT_BAD_ADDR] = bad_addr_i;          // R12
         pattern_o[rcs_pkg::BIT_WAKEUP]   = wakeup_i;            // R13
      end
   end
endmodule

// file: verification/rcs_sva.sv
// checker for the reset cause capture block, bound to its top ports
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ns
module rcs_sva (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       cyc_i,
   input wire logic       stb_i,
   input wire logic       we_i,
   input wire logic [4:0] adr_i,
   input wire logic       ack_o,
   input wire logic       debug_access_i,
   input wire logic       watchdog_restart_o,
   input wire logic       reset_req_o,
   input wire logic [7:0] reset_cause_status_o
);
   // -----------------------------------------------------------
   // properties
   // -----------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic tk_w;
   // a write request that the slave takes on this edge
   assign tk_w = cyc_i && stb_i && we_i && !ack_o;
   property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   property p_ack_pulse; ack_o |=> !ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
   property p_bit0; reset_cause_status_o[0] == 1'b0; endproperty
   a_bit0: assert property (p_bit0) else $error("bit0 set");
   // status only moves while reset is seen, output lags one cycle
   property p_hold;
      !$past(rst_i) && !$past(rst_i, 2) |-> $stable(reset_cause_status_o);
   endproperty
   a_hold: assert property (p_hold) else $error("status moved");
   property p_kick; tk_w && adr_i == 5'h00 |-> ##2 watchdog_restart_o;
   endproperty
   a_kick: assert property (p_kick) else $error("no restart");
   property p_kick_why;
      watchdog_restart_o |-> $past(ack_o && we_i && adr_i == 5'h00);
   endproperty
   a_kick_why: assert property (p_kick_why) else $error("odd restart");
   property p_user_force;
      tk_w && adr_i == 5'h04 && !debug_access_i && !reset_req_o
         |-> !reset_req_o [*4];
   endproperty
   a_user_force: assert property (p_user_force) else $error("user reset");
   property p_req_hold; reset_req_o |=> reset_req_o; endproperty
   a_req_hold: assert property (p_req_hold) else $error("req dropped");
   c_kick: cover property (tk_w && adr_i == 5'h00);
   c_req: cover property ($rose(reset_req_o));
   c_user: cover property (tk_w && adr_i == 5'h04 && !debug_access_i);
endmodule

// file: verification/reset_cause_status_capture_tb_top.sv
// self-checking bench for the reset cause capture block
// assumes the bench is the only bus master and the cause source
`timescale 1ns/1ns
module reset_cause_status_capture_tb_top;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
   logic [3:0] sel_i = 4'h0;
   logic [4:0] adr_i = 5'h00;
   logic [31:0] dat_i = 32'h0, dat_o, q;
   logic ack_o, wd_o, req_o, irq_o, a, b;
   logic [7:0] st_o, e;
   logic pwr = 1, low = 0, pin_n = 1, wdt = 0, bop = 0, stp = 0;
   logic bgn = 0, bad = 0, wku = 0, s12 = 0, dbg = 0;
   integer n_fail = 0, checks_done = 0, seed = 32'h63a6, i, r, k;
   always #5 clk_i = ~clk_i;
   reset_cause_status_capture dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .debug_access_i(dbg),
      .power_on_i(pwr), .supply_low_i(low), .reset_pin_n_i(pin_n),
      .watchdog_timeout_i(wdt), .bad_opcode_i(bop), .stop_exec_i(stp),
      .enter_background_instruction_exec_i(bgn), .bad_address_i(bad), .wakeup_i(wku),
      .stop12_mode_i(s12), .watchdog_restart_o(wd_o),
      .reset_req_o(req_o), .reset_cause_status_o(st_o), .irq_o(irq_o));
   // -----------------------------------------------------------
   // tasks
   // -----------------------------------------------------------
   task report_and_stop;
      $display("mismatches %0d comparisons %0d", n_fail, checks_done);
      if (n_fail == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      checks_done++;
      if (g !== x) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
      end
   endtask
   // classic cycle: hold until ack is high at a rising edge
   task wb(input logic w, input logic [4:0] ad, input logic [31:0] d);
      cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= ad; dat_i <= d;
      sel_i <= 4'hf;
      k = 0;
      // ack and dat_o are sampled at the edge, before they update
      do begin @(posedge clk_i); k++; end
      while (ack_o !== 1'b1 && k < 20);
      if (k >= 20) begin n_fail++; report_and_stop; end
      q = dat_o;
      cyc_i <= 0; stb_i <= 0; we_i <= 0;
      @(posedge clk_i);
   endtask
   // causes are held through the whole reset, then withdrawn
   task do_rst;
      rst_i <= 1;
      repeat (5) @(posedge clk_i);
      rst_i <= 0;
      {pwr, low, wdt, bop, stp, bgn, bad, wku} <= 8'h00;
      pin_n <= 1;
      @(posedge clk_i);
   endtask
   task rd_st(input logic [7:0] x);
      wb(0, 5'h00, 32'h0);
      chk("status", {24'h0, x}, q);
      chk("status_o", {24'h0, x}, {24'h0, st_o});
   endtask
   function logic [7:0] exp_other(input logic [3:0] c);
      return {1'b0, c, 3'b000};
   endfunction
   // -----------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 0;
      pwr <= 0;
      @(posedge clk_i);
      rd_st(8'h82);
      for (i = 0; i < 12; i++) begin
         r = $random(seed);
         if (i == 0) r[3:0] = 4'hf;
         if (i == 1) r[3:0] = 4'h0;
         pin_n <= ~r[3]; wdt <= r[2]; bad <= r[0]; wku <= r[4];
         s12 <= r[6]; // wakeup out of stop2/1 is not flagged here
         case (i % 3)
            0: bop <= r[1];
            1: stp <= r[1];
            default: bgn <= r[1];
         endcase
         do_rst;
         e = exp_other(r[3:0]) | {5'h0, r[4] & ~r[6], 2'h0};
         rd_st(e);
         if (i < 3) begin
            pwr <= 1; low <= r[5]; pin_n <= 0; wdt <= 1; bad <= 1;
            do_rst;
            e = 8'h82;
            rd_st(e);
         end
      end
      wb(1, 5'h00, $random(seed));
      rd_st(e);
      wb(1, 5'h14, 32'hffffffff);
      wb(0, 5'h14, 32'h0);
      chk("unmapped", 32'h0, q);
      wb(1, 5'h10, 32'h0);
      wb(1, 5'h0c, 32'h3);
      wb(1, 5'h00, 32'h0);
      @(posedge clk_i); // restart event reaches irq status a cycle later
      wb(0, 5'h0c, 32'h0);
      chk("irq_stat", 32'h1, q & 32'h1);
      @(posedge clk_i);
      a = irq_o;
      wb(1, 5'h10, 32'h1);
      @(posedge clk_i);
      b = irq_o;
      chk("irq_mask", 32'h2, {30'h0, b, a});
      wb(1, 5'h0c, 32'h1);
      @(posedge clk_i);
      chk("irq_clear", 32'h0, {31'h0, irq_o});
      wb(1, 5'h04, 32'h1);
      chk("req_user", 32'h0, {31'h0, req_o});
      dbg <= 1;
      wb(1, 5'h04, 32'h1);
      dbg <= 0;
      k = 0;
      while (req_o !== 1'b1 && k < 10) begin @(posedge clk_i); k++; end
      chk("req_debug", 32'h1, {31'h0, req_o});
      pin_n <= 0;
      do_rst;
      rd_st(8'h00);
      report_and_stop;
   end
endmodule
bind reset_cause_status_capture rcs_sva chk_u (.clk_i, .rst_i, .cyc_i,
   .stb_i, .we_i, .adr_i, .ack_o, .debug_access_i, .watchdog_restart_o,
   .reset_req_o, .reset_cause_status_o);
